/* File: src/cycle_timer.sv */
/*
 down counter that holds a return operation for its instruction cycles.
 assumes a start pulse on the same clock.
*/
`timescale 1ns/1ps
module cycle_timer #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic [W-1:0] cycles,
  output logic busy,
  output logic last
);
  logic [W-1:0] count;
  assign busy = (count != '0);
  assign last = (count == {{(W-1){1'b0}}, 1'b1});
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (start) begin
      count <= cycles;
    end else if (busy) begin
      count <= count - {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // cycle_timer

/* File: src/retseq_map.svh */
/*
 offsets, reset values, opcode patterns and cycle counts of the return sequencer.
 assumes inclusion by bare name from src/.
*/
`ifndef RETSEQ_MAP_SVH
`define RETSEQ_MAP_SVH
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_SPTR 8'h08
`define OFF_PCLO 8'h0c
`define OFF_CORE 8'h10
`define OFF_RSTCTL 8'h14
`define OFF_INSTR 8'h18
`define OFF_POPLO 8'h1c
`define OFF_POPHI 8'h20
`define OFF_WREG 8'h40
`define OP_IRET 24'h064000
`define OP_LRET_PFX 9'h00a
`define RSTCTL_SWRESET 16'h0040
`define CORE_SWRESET 16'h0020
`define SP_SWRESET 16'h0800
`define SP_POP_STEP 16'h0004
`define CYC_BASE 4'h3
`define CYC_EXT 4'h6
`define CORE_PRIO_BIT 3
`define SR_RA_BIT 4
`endif

/* File: src/retseq_pkg.sv */
/*
 types of the return sequencer.
 assumes nothing beyond the map header.
*/
package retseq_pkg;
  typedef enum {ST_IDLE, ST_RUN, ST_DONE} seq_state_t;
  typedef logic [15:0] word_t;
endpackage

/* File: src/return_instruction_sequencer.sv */
/*
 return sequencer: decodes the interrupt return and literal return opcodes,
 restores status, priority and frame flag, pops two stack words.
 assumes an APB master on CLK; software posts instruction and popped words.
*/
// Notes on behaviour
// - the interrupt return opcode is the fixed word 0x064000 with no operands.
// - on the extended core interrupt return also restores the stack-frame flag.
// - baseline returns take three cycles, two with an exception pending.
// - extended interrupt return takes six cycles, five with an exception pending.
// - interrupt return restores the priority level including the high bit in core control.
// - literal return is prefix 0000 0101 0, byte bit, ten-bit literal, destination nibble.
// - literal return writes the literal, limited to eight bits in byte mode.
// - software reset sets the reset flag (0x0040) and clears working registers but the stack.
// - software reset leaves core control at 0x0020 and the program counter at zero.
`timescale 1ns/1ps
`include "retseq_map.svh"
module return_instruction_sequencer #(
  parameter bit EXTENDED_CORE = 1'b0
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EXC_PENDING,
  output logic SEQ_BUSY
);
  import retseq_pkg::*;

  seq_state_t state;
  logic exc_s1, exc_s2;
  retseq_pkg::word_t working_register [0:15];
  retseq_pkg::word_t cpu_status_register, core_control_register, reset_control_register;
  retseq_pkg::word_t pc_lo, pop_lo, pop_hi;
  logic [6:0] pc_hi;
  logic stack_frame_active_flag;
  logic [23:0] instr;
  logic is_iret, is_lret, busy, last, start, wr, rd, wr_instr, wr_ctrl, sw_reset, hit;
  logic [3:0] cycles, next_cycles, run_len;
  logic [31:0] next_rdata;
  retseq_pkg::word_t lit_val;

  function automatic retseq_pkg::word_t pad16(input logic [9:0] v);
    pad16 = {6'h00, v};
  endfunction

  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && !PWRITE;
  assign PREADY = 1'b1;
  assign wr_instr = wr && (PADDR == `OFF_INSTR);
  assign wr_ctrl = wr && (PADDR == `OFF_CTRL);
  assign sw_reset = wr_ctrl && PWDATA[1];
  assign is_iret = (instr == `OP_IRET);
  assign is_lret = (instr[23:15] == `OP_LRET_PFX);
  // byte mode keeps eight bits
  // byte mode replaces only the low byte of the destination
  assign lit_val = instr[14] ? {working_register[instr[3:0]][15:8], instr[11:4]}
                             : pad16(instr[13:4]);
  assign start = wr_ctrl && PWDATA[0] && (state == ST_IDLE) && (is_iret || is_lret);
  assign next_cycles = ((EXTENDED_CORE && is_iret) ? `CYC_EXT : `CYC_BASE)
                     - {3'h0, exc_s2};
  assign SEQ_BUSY = (state != ST_IDLE);
  assign hit = (PADDR[7:6] == 2'b01) || (PADDR <= `OFF_POPHI);
  assign PSLVERR = PSEL && PENABLE && !hit;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (PADDR[7:6] == 2'b01) begin
      next_rdata = {16'h0000, working_register[PADDR[5:2]]};
    end else begin
      case (PADDR)
        `OFF_CTRL: next_rdata = {31'h0, SEQ_BUSY};
        `OFF_STATUS: next_rdata = {15'h0, stack_frame_active_flag, cpu_status_register};
        `OFF_SPTR: next_rdata = {16'h0, working_register[15]};
        `OFF_PCLO: next_rdata = {9'h0, pc_hi, pc_lo};
        `OFF_CORE: next_rdata = {16'h0, core_control_register};
        `OFF_RSTCTL: next_rdata = {16'h0, reset_control_register};
        `OFF_INSTR: next_rdata = {8'h0, instr};
        `OFF_POPLO: next_rdata = {16'h0, pop_lo};
        `OFF_POPHI: next_rdata = {16'h0, pop_hi};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  cycle_timer #(.W(4)) timer (
    .clk(CLK),
    .arst_n(ARST_N),
    .start(start),
    .cycles(next_cycles),
    .busy(busy),
    .last(last)
  );

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      exc_s1 <= 1'b0;
      exc_s2 <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      exc_s1 <= EXC_PENDING;
      exc_s2 <= exc_s1;
      PRDATA <= rd ? next_rdata : PRDATA;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= ST_IDLE;
      cycles <= 4'h0;
    end else begin
      case (state)
        ST_IDLE: if (start) begin
          state <= ST_RUN;
          cycles <= next_cycles;
        end
        ST_RUN: if (last) state <= ST_DONE;
        ST_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < 16; i++) working_register[i] <= 16'h0000;
      cpu_status_register <= 16'h0000;
      core_control_register <= 16'h0000;
      reset_control_register <= 16'h0000;
      pc_lo <= 16'h0000;
      pc_hi <= 7'h00;
      pop_lo <= 16'h0000;
      pop_hi <= 16'h0000;
      instr <= 24'h000000;
      stack_frame_active_flag <= 1'b0;
    end else if (sw_reset) begin
      for (int i = 0; i < 15; i++) working_register[i] <= 16'h0000;
      working_register[15] <= `SP_SWRESET;
      reset_control_register <= `RSTCTL_SWRESET;
      core_control_register <= `CORE_SWRESET;
      cpu_status_register <= 16'h0000;
      pc_lo <= 16'h0000;
      pc_hi <= 7'h00;
      stack_frame_active_flag <= 1'b0;
    end else if (state == ST_DONE) begin
      working_register[15] <= working_register[15] - `SP_POP_STEP;
      pc_hi <= pop_hi[6:0];
      pc_lo <= EXTENDED_CORE ? {pop_lo[15:1], 1'b0} : pop_lo;
      if (EXTENDED_CORE) stack_frame_active_flag <= pop_lo[0];
      if (is_iret) begin
        cpu_status_register[7:0] <= pop_hi[15:8];
        core_control_register[`CORE_PRIO_BIT] <= pop_hi[7];
      end else begin
        working_register[instr[3:0]] <= lit_val;
      end
    end else if (wr) begin
      if (PADDR[7:6] == 2'b01) working_register[PADDR[5:2]] <= PWDATA[15:0];
      if (wr_instr) instr <= PWDATA[23:0];
      if (PADDR == `OFF_POPLO) pop_lo <= PWDATA[15:0];
      if (PADDR == `OFF_POPHI) pop_hi <= PWDATA[15:0];
      if (PADDR == `OFF_CORE) core_control_register <= PWDATA[15:0];
      if (PADDR == `OFF_STATUS) cpu_status_register <= PWDATA[15:0];
    end
  end

  // helper: cycles spent in the run state, held against the loaded budget
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      run_len <= 4'h0;
    end else if (start) begin
      run_len <= 4'h0;
    end else if (state == ST_RUN) begin
      run_len <= run_len + 4'h1;
    end
  end

  sequence s_run_last;
    (state == ST_RUN) && last;
  endsequence

  chk_cycle_budget: assert property (@(posedge CLK) disable iff (!ARST_N)
    start |=> (state == ST_RUN) ##0 busy) else $error("return not held busy");
  chk_run_length: assert property (@(posedge CLK) disable iff (!ARST_N)
    s_run_last |-> ((run_len + 4'h1) == cycles))
    else $error("return ran the wrong number of cycles");
  chk_stack_step: assert property (@(posedge CLK) disable iff (!ARST_N)
    (state == ST_DONE && !sw_reset) |=>
      working_register[15] == $past(working_register[15]) - `SP_POP_STEP)
    else $error("stack pointer not popped by four");
  chk_swreset_flag: assert property (@(posedge CLK) disable iff (!ARST_N)
    sw_reset |=> reset_control_register == `RSTCTL_SWRESET && pc_lo == 16'h0000)
    else $error("software reset state wrong");
  chk_swreset_core: assert property (@(posedge CLK) disable iff (!ARST_N)
    sw_reset |=> core_control_register == `CORE_SWRESET)
    else $error("core control not reset");
  chk_iret_status: assert property (@(posedge CLK) disable iff (!ARST_N)
    (state == ST_DONE && is_iret && !sw_reset) |=>
      cpu_status_register[7:0] == $past(pop_hi[15:8]) &&
      core_control_register[`CORE_PRIO_BIT] == $past(pop_hi[7]) &&
      cpu_status_register[15:8] == $past(cpu_status_register[15:8]))
    else $error("status or priority not restored");
  // run leaves after the last cycle
  chk_run_ends: assert property (@(posedge CLK) disable iff (!ARST_N)
    s_run_last |=> state == ST_DONE) else $error("run overran");
endmodule // return_instruction_sequencer

/* File: tb/return_instruction_sequencer_tb_top.sv */
/* bench for the return sequencer: base and extended cores share one apb bus.
 assumes the map header on the include path and zero-wait slaves. */
`timescale 1ns/1ps
`include "retseq_map.svh"
module return_instruction_sequencer_tb_top;
  import retseq_pkg::*;
  logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, exc = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd_b, rd_x, q_b, q_x;
  logic rdy_b, rdy_x, err_b, err_x, busy_b, busy_x, e_b, e_x;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  always #5 clk = ~clk;
  return_instruction_sequencer #(.EXTENDED_CORE(1'b0)) return_instruction_sequencer_inst (
    .CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(rd_b), .PREADY(rdy_b), .PSLVERR(err_b),
    .EXC_PENDING(exc), .SEQ_BUSY(busy_b));
  // both instances see the same traffic, so timing differs only by core kind
  return_instruction_sequencer #(.EXTENDED_CORE(1'b1)) return_instruction_sequencer_inst_ext (
    .CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(rd_x), .PREADY(rdy_x), .PSLVERR(err_x),
    .EXC_PENDING(exc), .SEQ_BUSY(busy_x));
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      test_done;
    end
  end
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (rdy_b !== 1'b1 || rdy_x !== 1'b1);
    q_b = rd_b;
    q_x = rd_x;
    e_b = err_b;
    e_x = err_x;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input string nm, input logic [31:0] m, eb, ex);
    apb(1'b0, a, 32'h0);
    cmp({nm, " base"}, eb, q_b & m);
    cmp({nm, " ext"}, ex, q_x & m);
  endtask
  // busy is counted over a fixed window; it covers run cycles plus the done cycle
  task run(input logic [23:0] op, input logic [15:0] lo, hi, input logic x, input int nb, nx);
    int cb, cx;
    cb = 0; cx = 0;
    exc <= x;
    apb(1'b1, `OFF_INSTR, {8'h00, op});
    apb(1'b1, `OFF_POPLO, {16'h0, lo});
    apb(1'b1, `OFF_POPHI, {16'h0, hi});
    apb(1'b1, `OFF_CTRL, 32'h1);
    repeat (20) @(posedge clk) begin
      cb += (busy_b === 1'b1);
      cx += (busy_x === 1'b1);
    end
    cmp("busy cycles base", nb, cb);
    cmp("busy cycles ext", nx, cx);
    exc <= 1'b0;
  endtask
  task t_swreset;
    rd(`OFF_RSTCTL, "rstctl after reset", 32'hffff, 32'h0, 32'h0);
    apb(1'b1, `OFF_CTRL, 32'h2);
    repeat (4) @(posedge clk);
    rd(`OFF_RSTCTL, "rstctl", 32'hffff, 32'h0040, 32'h0040);
    rd(`OFF_CORE, "core", 32'hffff, 32'h0020, 32'h0020);
    rd(`OFF_PCLO, "pc", 32'h7fffff, 32'h0, 32'h0);
    rd(`OFF_SPTR, "sp", 32'hffff, 32'h0800, 32'h0800);
    rd(`OFF_WREG, "w0", 32'hffff, 32'h0, 32'h0);
  endtask
  task t_iret;
    run(`OP_IRET, 16'h0231, 16'h8181, 1'b0, 4, 7);
    rd(`OFF_SPTR, "sp", 32'hffff, 32'h07fc, 32'h07fc);
    rd(`OFF_PCLO, "pc", 32'h7fffff, 32'h10231, 32'h10230);
    rd(`OFF_STATUS, "status", 32'h100ff, 32'h81, 32'h10081);
    rd(`OFF_CORE, "core", 32'hffff, 32'h0028, 32'h0028);
    run(`OP_IRET, 16'h0100, 16'h0000, 1'b1, 3, 6);
    rd(`OFF_SPTR, "sp", 32'hffff, 32'h07f8, 32'h07f8);
    rd(`OFF_CORE, "core", 32'hffff, 32'h0020, 32'h0020);
    rd(`OFF_STATUS, "status", 32'h100ff, 32'h0, 32'h0);
  endtask
  task t_lret;
    apb(1'b1, `OFF_WREG, 32'h9846);
    run({`OP_LRET_PFX, 1'b1, 10'h00a, 4'h0}, 16'h7006, 16'h0, 1'b0, 4, 4);
    rd(`OFF_WREG, "w0", 32'hffff, 32'h980a, 32'h980a);
    run({`OP_LRET_PFX, 1'b0, 10'h230, 4'h2}, 16'h7008, 16'h1, 1'b1, 3, 3);
    rd(`OFF_WREG + 8'h08, "w2", 32'hffff, 32'h0230, 32'h0230);
    rd(`OFF_SPTR, "sp", 32'hffff, 32'h07f0, 32'h07f0);
  endtask
  task t_refuse;
    run(24'h060000, 16'h1234, 16'h0, 1'b0, 0, 0);
    rd(`OFF_SPTR, "sp", 32'hffff, 32'h07f0, 32'h07f0);
    cmp("slverr mapped", 32'h0, {31'h0, e_b});
    apb(1'b0, 8'h3c, 32'h0);
    cmp("slverr", 32'h1, {31'h0, e_b});
    cmp("slverr ext", 32'h1, {31'h0, e_x});
  endtask
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    t_swreset;
    t_iret;
    t_lret;
    t_refuse;
    test_done;
  end
endmodule // return_instruction_sequencer_tb_top
